// file: hw/led_pwm_pkg.sv
// constants and carrier types for the led string pwm controller
// assumes one controller per package user; register space is 8 bits
package led_pwm_pkg;
  localparam int          NSTR         = 16;
  localparam int          NREG         = 96;
  localparam logic [7:0]  REG_LAST     = 8'h5f;
  localparam logic [7:0]  REG_EN_LO    = 8'h00;
  localparam logic [7:0]  REG_EN_HI    = 8'h01;
  localparam logic [7:0]  REG_OPT      = 8'h0b;
  localparam logic [7:0]  REG_ISCALE   = 8'h0f;
  localparam logic [7:0]  REG_FRM_CTL  = 8'h18;
  localparam logic [7:0]  REG_FRM_LO   = 8'h19;
  localparam logic [7:0]  REG_FRM_HI   = 8'h1a;
  localparam logic [7:0]  REG_PWM_CTL  = 8'h1e;
  localparam logic [7:0]  REG_INTENS   = 8'h1f;
  localparam logic [7:0]  REG_GROUP    = 8'h20;
  localparam logic [7:0]  REG_DELAY    = 8'h30;
  localparam logic [7:0]  REG_ONTIME   = 8'h40;
  // pwm_control fields, then frame control and optimisation bits, group width and shifts
  localparam int          PWM_ENGINE_ENABLE_BIT   = 0;
  localparam int          DIRECT_DRIVE_SELECT_BIT = 1;
  localparam int          DIRECT_DELAY_BIT        = 2;
  localparam int          GLOBAL_GATE_BIT         = 3;
  localparam int          SPREAD_BIT              = 4;
  localparam int          INTENSITY_EN_BIT        = 5;
  localparam int          FRM_INTERNAL_BIT        = 0;
  localparam int          OPT_PERIODIC_BIT        = 1;
  localparam int          GROUP_W      = 2;
  localparam int          SPREAD_SHIFT = 4;
  localparam int          INTENS_SHIFT = 8;
  localparam int          OPT_FRAMES   = 256;

  typedef enum {st_off, st_boot, st_run} boot_state_e;

  typedef struct packed {
    logic [NSTR-1:0][11:0] ontime;
    logic [NSTR-1:0][7:0]  delay;
    logic [NSTR-1:0]       str_en;
    logic [7:0]            ctrl;
    logic [7:0]            intensity;
    logic [15:0]           frame_len;
    logic                  internal_frame;
  } pwm_cfg_s;
endpackage

// file: hw/led_string_pwm_control.sv
// led string pwm controller: register store, boot load, pwm engine
// assumes a one-cycle-latency nonvolatile read port on clk and a
// free-running grayscale clock; serial host decode sits outside
`timescale 1ns/10ps
module led_string_pwm_control
  import led_pwm_pkg::*;
#(
  parameter int OPT_N = OPT_FRAMES
) (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           gsc_clk,
  input  wire logic                           dev_enable,
  input  wire logic                           frame_sync_input,
  input  wire logic                           pwm_in,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [7:0]                     reg_wdata,
  output logic [7:0]                          reg_rdata,
  output logic                                nvm_rd,
  output logic [7:0]                          nvm_addr,
  input  wire logic [7:0]                     nvm_rdata,
  output logic                                low_power,
  output logic                                boot_busy,
  output logic [led_pwm_pkg::NSTR-1:0]        str_drive,
  output logic [7:0]                          string_current_scale,
  output logic [led_pwm_pkg::NSTR*2-1:0]      string_supply_group,
  output logic                                opt_req
);
  import led_pwm_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers (clk)
  // ------------------------------------------------------------
  logic [2:0]  en_sync_ff;
  logic [1:0]  pwm_sync_ff;
  logic        pwm_prev_ff;
  always_ff @(posedge clk) begin
    en_sync_ff  <= {en_sync_ff[1:0], dev_enable};
    pwm_sync_ff <= {pwm_sync_ff[0], pwm_in};
    pwm_prev_ff <= pwm_sync_ff[1];
  end
  wire en_on   = en_sync_ff[1];
  wire en_rise = en_sync_ff[1] & ~en_sync_ff[2];
  wire pwm_s   = pwm_sync_ff[1];

  // ------------------------------------------------------------
  // boot loader
  // ------------------------------------------------------------
  boot_state_e state_ff;
  logic [7:0]  idx_ff;
  logic        nvm_rd_ff;
  logic [7:0]  nvm_addr_ff;
  logic        ld_ff;
  logic [7:0]  ld_addr_ff;
  logic        boot_done_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff     <= st_boot;
      idx_ff       <= 8'h00;
      nvm_rd_ff    <= 1'b0;
      nvm_addr_ff  <= 8'h00;
      ld_ff        <= 1'b0;
      ld_addr_ff   <= 8'h00;
      boot_done_ff <= 1'b0;
    end else begin
      ld_ff        <= nvm_rd_ff;
      ld_addr_ff   <= nvm_addr_ff;
      nvm_rd_ff    <= 1'b0;
      boot_done_ff <= 1'b0;
      if (!en_on) begin
        state_ff <= st_off;
        idx_ff   <= 8'h00;
      end else if (en_rise) begin
        state_ff <= st_boot;
        idx_ff   <= 8'h00;
      end else begin
        case (state_ff)
          st_boot: begin
            if (idx_ff <= REG_LAST) begin
              nvm_rd_ff   <= 1'b1;
              nvm_addr_ff <= idx_ff;
              idx_ff      <= idx_ff + 8'h01;
            end
            if (ld_ff && ld_addr_ff == REG_LAST) begin
              state_ff     <= st_run;
              boot_done_ff <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end
  wire running = (state_ff == st_run) && en_on;

  // ------------------------------------------------------------
  // register store and host port
  // ------------------------------------------------------------
  logic [7:0] regs_ff [0:NREG-1];
  logic [7:0] rdata_ff;
  logic       cfg_tgl_ff;
  wire        host_wr = running && reg_wr && reg_addr <= REG_LAST;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int r = 0; r < NREG; r++) begin
        regs_ff[r] <= 8'h00;
      end
    end else if (ld_ff && state_ff == st_boot) begin
      regs_ff[ld_addr_ff[6:0]] <= nvm_rdata;
    end else if (host_wr) begin
      regs_ff[reg_addr[6:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (running && reg_rd && reg_addr <= REG_LAST) begin
      rdata_ff <= regs_ff[reg_addr[6:0]];
    end else if (reg_rd) begin
      rdata_ff <= 8'h00;
    end
  end

  // flags the engine domain to take a fresh copy of the settings
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_tgl_ff <= 1'b0;
    end else if (host_wr || boot_done_ff) begin
      cfg_tgl_ff <= ~cfg_tgl_ff;
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  pwm_cfg_s cfg;
  wire [7:0] pwm_ctl = regs_ff[REG_PWM_CTL[6:0]];
  always_comb begin
    cfg.str_en    = {regs_ff[REG_EN_HI[6:0]], regs_ff[REG_EN_LO[6:0]]};
    cfg.ctrl      = pwm_ctl;
    cfg.intensity = regs_ff[REG_INTENS[6:0]];
    cfg.frame_len = {regs_ff[REG_FRM_HI[6:0]], regs_ff[REG_FRM_LO[6:0]]};
    cfg.internal_frame = regs_ff[REG_FRM_CTL[6:0]][FRM_INTERNAL_BIT];
    for (int i = 0; i < NSTR; i++) begin
      cfg.delay[i]  = regs_ff[REG_DELAY[6:0] + 7'(i)];
      cfg.ontime[i] = {regs_ff[REG_ONTIME[6:0] + 7'(2*i+1)][3:0],
                       regs_ff[REG_ONTIME[6:0] + 7'(2*i)]};
    end
  end

  // ------------------------------------------------------------
  // grayscale-clock domain: engine
  // ------------------------------------------------------------
  logic [1:0]  grst_ff;
  logic [2:0]  gtgl_ff;
  logic [2:0]  fsync_ff;
  pwm_cfg_s    gcfg_ff;
  logic [15:0] gcnt_ff;
  logic [15:0] period_ff;
  logic        frm_tgl_ff;
  logic [NSTR-1:0] eng_ff;
  wire grst_n = grst_ff[1];
  always_ff @(posedge gsc_clk) begin
    grst_ff  <= {grst_ff[0], resetn};
    gtgl_ff  <= {gtgl_ff[1:0], cfg_tgl_ff};
    fsync_ff <= {fsync_ff[1:0], frame_sync_input};
  end

  // settings are quiet for several edges after each flag toggle
  always_ff @(posedge gsc_clk) begin
    if (!grst_n) begin
      gcfg_ff <= '0;
    end else if (gtgl_ff[2] != gtgl_ff[1]) begin
      gcfg_ff <= cfg;
    end
  end

  wire [15:0] flen  = gcfg_ff.frame_len;
  wire frm_start = gcfg_ff.internal_frame
                   ? (gcnt_ff >= flen - 16'h0001)
                   : (fsync_ff[1] & ~fsync_ff[2]);
  always_ff @(posedge gsc_clk) begin
    if (!grst_n) begin
      gcnt_ff    <= 16'h0000;
      period_ff  <= 16'h0000;
      frm_tgl_ff <= 1'b0;
    end else if (frm_start) begin
      gcnt_ff    <= 16'h0000;
      period_ff  <= gcfg_ff.internal_frame ? flen
                                           : gcnt_ff + 16'h0001;
      frm_tgl_ff <= ~frm_tgl_ff;
    end else begin
      gcnt_ff <= gcnt_ff + 16'h0001;
    end
  end

  wire [15:0] step = period_ff >> SPREAD_SHIFT;
  wire gspread = gcfg_ff.ctrl[SPREAD_BIT];
  wire gint_en = gcfg_ff.ctrl[INTENSITY_EN_BIT];
  generate
    for (genvar i = 0; i < NSTR; i++) begin : g_eng
      wire [19:0] prod = gcfg_ff.ontime[i] * gcfg_ff.intensity;
      wire [11:0] onlen = gint_en ? prod[INTENS_SHIFT +: 12]
                                  : gcfg_ff.ontime[i];
      wire [15:0] spr = gspread ? 16'(step * i) : 16'h0000;
      wire [15:0] off = spr + {8'h00, gcfg_ff.delay[i]};
      wire [16:0] rel = (gcnt_ff >= off)
                        ? {1'b0, gcnt_ff - off}
                        : {1'b0, gcnt_ff} + {1'b0, period_ff}
                          - {1'b0, off};
      always_ff @(posedge gsc_clk) begin
        if (!grst_n) begin
          eng_ff[i] <= 1'b0;
        end else begin
          eng_ff[i] <= gcfg_ff.str_en[i]
                       && rel < {5'h00, onlen};
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // back in clk: engine bits and frame events
  // ------------------------------------------------------------
  logic [NSTR-1:0] eng_s1_ff;
  logic [NSTR-1:0] eng_s2_ff;
  logic [2:0]      ftgl_ff;
  always_ff @(posedge clk) begin
    eng_s1_ff <= eng_ff;
    eng_s2_ff <= eng_s1_ff;
    ftgl_ff   <= {ftgl_ff[1:0], frm_tgl_ff};
  end
  wire frame_evt = ftgl_ff[2] != ftgl_ff[1];

  // ------------------------------------------------------------
  // direct drive from the pwm pin
  // ------------------------------------------------------------
  logic [15:0] tcnt_ff;
  logic [15:0] dper_ff;
  logic [15:0] dhi_ff;
  wire pwm_rise = pwm_s & ~pwm_prev_ff;
  wire pwm_fall = ~pwm_s & pwm_prev_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tcnt_ff <= 16'h0000;
      dper_ff <= 16'h0000;
      dhi_ff  <= 16'h0000;
    end else if (pwm_rise) begin
      tcnt_ff <= 16'h0000;
      dper_ff <= tcnt_ff + 16'h0001;
    end else begin
      tcnt_ff <= tcnt_ff + 16'h0001;
      if (pwm_fall) begin
        dhi_ff <= tcnt_ff + 16'h0001;
      end
    end
  end

  wire [15:0] dstep = dper_ff >> SPREAD_SHIFT;
  logic [NSTR-1:0] direct_on;
  generate
    for (genvar i = 0; i < NSTR; i++) begin : g_dir
      wire [15:0] doff = 16'(dstep * i);
      wire [16:0] drel = (tcnt_ff >= doff)
                         ? {1'b0, tcnt_ff - doff}
                         : {1'b0, tcnt_ff} + {1'b0, dper_ff}
                           - {1'b0, doff};
      // delayed copies replay the last measured pulse, string i lagging by i/16 of the measured period
      assign direct_on[i] = pwm_ctl[DIRECT_DELAY_BIT]
                            ? drel < {1'b0, dhi_ff}
                            : pwm_s;
    end
  endgenerate

  // ------------------------------------------------------------
  // string outputs and static outputs
  // ------------------------------------------------------------
  logic [NSTR-1:0]   drive_ff;
  wire eng_en = pwm_ctl[PWM_ENGINE_ENABLE_BIT];
  wire direct = eng_en & pwm_ctl[DIRECT_DRIVE_SELECT_BIT];
  wire gate   = pwm_ctl[GLOBAL_GATE_BIT] ? pwm_s : 1'b1;
  always_ff @(posedge clk) begin
    if (!resetn || !running || !eng_en) begin
      drive_ff <= '0;
    end else if (direct) begin
      drive_ff <= direct_on & cfg.str_en;
    end else begin
      drive_ff <= eng_s2_ff & {NSTR{gate}};
    end
  end

  logic [7:0]        scale_ff;
  logic [NSTR*2-1:0] group_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scale_ff <= 8'h00;
      group_ff <= '0;
    end else begin
      scale_ff <= regs_ff[REG_ISCALE[6:0]];
      for (int i = 0; i < NSTR; i++) begin
        group_ff[i*GROUP_W +: GROUP_W] <=
          regs_ff[REG_GROUP[6:0] + 7'(i)][GROUP_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // periodic supply optimisation
  // ------------------------------------------------------------
  logic [15:0] opt_cnt_ff;
  logic        opt_ff;
  always_ff @(posedge clk) begin
    if (!resetn || !running
        || !regs_ff[REG_OPT[6:0]][OPT_PERIODIC_BIT]) begin
      opt_cnt_ff <= 16'h0000;
      opt_ff     <= 1'b0;
    end else begin
      opt_ff <= 1'b0;
      if (frame_evt) begin
        if (opt_cnt_ff >= 16'(OPT_N - 1)) begin
          opt_cnt_ff <= 16'h0000;
          opt_ff     <= 1'b1;
        end else begin
          opt_cnt_ff <= opt_cnt_ff + 16'h0001;
        end
      end
    end
  end

  logic lp_ff;
  logic busy_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lp_ff   <= 1'b0;
      busy_ff <= 1'b1;
    end else begin
      lp_ff   <= !en_on;
      busy_ff <= (state_ff == st_boot) && en_on;
    end
  end

  assign reg_rdata            = rdata_ff;
  assign nvm_rd               = nvm_rd_ff;
  assign nvm_addr             = nvm_addr_ff;
  assign low_power            = lp_ff;
  assign boot_busy            = busy_ff;
  assign str_drive            = drive_ff;
  assign string_current_scale = scale_ff;
  assign string_supply_group  = group_ff;
  assign opt_req              = opt_ff;
endmodule

// file: dv/led_nvm_model.sv
// nonvolatile default store answering the controller boot port
// assumes reads are strobed on the rising edge of clk
`timescale 1ns/10ps
module led_nvm_model (
  input  wire logic       clk,
  input  wire logic       nvm_rd,
  input  wire logic [7:0] nvm_addr,
  output logic [7:0]      nvm_rdata
);
  logic [7:0] mem [96];
  initial begin
    for (int i = 0; i < 96; i++) begin
      mem[i] = 8'(i * 37 + 19);
    end
  end
  // scrambled between reads so a late sample never matches by luck
  always @(posedge clk) begin
    if (nvm_rd) begin
      nvm_rdata <= mem[nvm_addr];
    end else begin
      nvm_rdata <= ~nvm_rdata;
    end
  end
endmodule

// file: dv/led_string_pwm_control_monitor.sv
// port checker for the led string pwm controller
// assumes it is bound onto every controller instance
`timescale 1ns/10ps
module led_string_pwm_control_monitor
  import led_pwm_pkg::*;
#(
  parameter int OPT_N = OPT_FRAMES
) (
  input wire logic                        clk,
  input wire logic                        resetn,
  input wire logic                        dev_enable,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic [7:0]                  reg_rdata,
  input wire logic                        nvm_rd,
  input wire logic [7:0]                  nvm_addr,
  input wire logic                        low_power,
  input wire logic                        boot_busy,
  input wire logic [7:0]                  string_current_scale,
  input wire logic [led_pwm_pkg::NSTR*2-1:0] string_supply_group,
  input wire logic                        opt_req
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic run;
  assign run = !boot_busy && !low_power;
  sequence s_step; nvm_rd && nvm_addr != REG_LAST; endsequence
  sequence s_next; nvm_rd && nvm_addr == $past(nvm_addr) + 8'h01; endsequence
  property p_walk; s_step |=> s_next; endproperty
  a_walk: assert property (p_walk)
    else $error("boot read walk broken");
  property p_done; $fell(boot_busy) |-> !nvm_rd; endproperty
  a_done: assert property (p_done)
    else $error("boot ended with a read pending");
  property p_wake; $rose(dev_enable) |-> ##[1:6] boot_busy; endproperty
  a_wake: assert property (p_wake)
    else $error("no reload after enable");
  property p_sleep; !dev_enable [*6] |-> low_power; endproperty
  a_sleep: assert property (p_sleep)
    else $error("no low power while disabled");
  property p_quiet; reg_rd && low_power |=> reg_rdata == 8'h00; endproperty
  a_quiet: assert property (p_quiet)
    else $error("host read answered while off");
  property p_scale;
    reg_wr && reg_addr == REG_ISCALE && run
      |=> ##1 string_current_scale == $past(reg_wdata, 2);
  endproperty
  a_scale: assert property (p_scale)
    else $error("current scale not updated");
  property p_group;
    reg_wr && reg_addr == REG_GROUP && run
      |=> ##1 string_supply_group[1:0] == $past(reg_wdata[1:0], 2);
  endproperty
  a_group: assert property (p_group)
    else $error("string group not updated");
  property p_opt; opt_req |=> !opt_req; endproperty
  a_opt: assert property (p_opt)
    else $error("optimise request longer than a cycle");
endmodule

bind led_string_pwm_control led_string_pwm_control_monitor #(
  .OPT_N(OPT_N)
) mon_u (
  .clk(clk), .resetn(resetn), .dev_enable(dev_enable), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
  .low_power(low_power), .boot_busy(boot_busy),
  .string_current_scale(string_current_scale),
  .string_supply_group(string_supply_group), .opt_req(opt_req));

// file: dv/tb_led_string_pwm_control.sv
// self-checking bench for the led string pwm controller
// assumes the nvm model and the bound port checker
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
  end end
module tb_led_string_pwm_control;
  import led_pwm_pkg::*;
  logic clk, gsc_clk, nvm_rd, low_power, boot_busy, opt_req;
  logic resetn = 1'b0, dev_enable = 1'b1, frame_sync_input = 1'b0;
  logic pwm_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sync_on = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, nvm_addr, nvm_rdata, scale, v;
  logic [15:0] drive, dprev;
  logic [31:0] groups;
  int num_errors, comparisons, exp_reg[96], k, inten, n, scnt;
  int len, d, p, el, ed, ep, q0, q1;
  logic [7:0] cctl[6] = '{8'h01, 8'h21, 8'h11, 8'h01, 8'h09, 8'h01};
  int cdly[6] = '{0, 0, 0, 6, 0, 0};
  led_string_pwm_control #(.OPT_N(4)) dut_u (
    .clk(clk), .resetn(resetn), .gsc_clk(gsc_clk),
    .dev_enable(dev_enable), .frame_sync_input(frame_sync_input),
    .pwm_in(pwm_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
    .low_power(low_power), .boot_busy(boot_busy), .str_drive(drive),
    .string_current_scale(scale), .string_supply_group(groups),
    .opt_req(opt_req));
  led_nvm_model nvm_u (.clk(clk), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
    .nvm_rdata(nvm_rdata));
  // ----------------------------------------
  // clocks, sync pin, host tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // gsc_clk edges fall at 1 ns plus multiples of 16 ns, and some meet clk edges (65 ns, 145 ns)
  initial begin
    gsc_clk = 1'b0;
    #1;
    forever #16 gsc_clk = ~gsc_clk;
  end
  always @(negedge clk) begin
    scnt <= (scnt == 319) ? 0 : scnt + 1;
    frame_sync_input <= sync_on && scnt < 16;
  end
  function automatic logic near(input int a, input int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction
  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // writes spaced out so the settings copy never misses one
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = dat;
    @(negedge clk);
    reg_wr = 1'b0;
    if (dev_enable && a <= REG_LAST) exp_reg[a] = dat;
    repeat (30) @(negedge clk);
  endtask
  task automatic rdc(input logic [7:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    `CHK("rdata", (dev_enable && a <= REG_LAST) ? 8'(exp_reg[a]) : 8'h00,
      reg_rdata)
  endtask
  task automatic boot();
    repeat (5) @(negedge clk);
    for (n = 0; n < 400 && boot_busy !== 1'b0; n++) @(negedge clk);
    if (n >= 400) begin
      num_errors++;
      results();
    end
    for (n = 0; n < 96; n++) exp_reg[n] = nvm_u.mem[n];
  endtask
  // one frame of on-time plus first rises, in grayscale cycles
  task automatic meas();
    int r0 = -1, r1 = -1, r2 = -1;
    logic [15:0] pv, s;
    len = 0;
    repeat (70) @(posedge gsc_clk);
    pv = drive;
    for (int i = 0; i < 200; i++) begin
      @(posedge gsc_clk);
      s = drive;
      if (s[0] && !pv[0] && r0 < 0) r0 = i;
      else if (s[0] && !pv[0] && r2 < 0) r2 = i;
      if (s[1] && !pv[1] && r0 >= 0 && r1 < 0) r1 = i;
      if (r0 >= 0 && r2 < 0 && s[0]) len++;
      pv = s;
    end
    d = r1 - r0;
    p = r2 - r0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(62));
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    boot();
    `CHK("scale", nvm_u.mem[8'h0f], scale)
    `CHK("group", nvm_u.mem[8'h20][1:0], groups[1:0])
    v = 8'($urandom);
    wr(REG_ISCALE, v);
    `CHK("scale", v, scale)
    rdc(REG_ISCALE);
    wr(REG_GROUP, ~v);
    `CHK("group", ~v[1:0], groups[1:0])
    wr(8'h60, v);
    rdc(8'h60);
    dev_enable = 1'b0;
    repeat (10) @(negedge clk);
    `CHK("low_power", 1'b1, low_power)
    wr(REG_ISCALE, ~v);
    rdc(REG_ISCALE);
    dev_enable = 1'b1;
    boot();
    rdc(REG_ISCALE);
    `CHK("scale", nvm_u.mem[8'h0f], scale)
    k = 8 + $urandom % 24;
    inten = $urandom % 256;
    wr(REG_EN_LO, 8'hff);
    wr(REG_EN_HI, 8'hff);
    for (n = 0; n < 4; n++) wr(REG_ONTIME + 8'(n), n[0] ? 8'h00 : 8'(k));
    wr(REG_DELAY, 8'h00);
    wr(REG_INTENS, 8'(inten));
    wr(REG_FRM_LO, 8'd64);
    wr(REG_FRM_HI, 8'h00);
    wr(REG_OPT, 8'h00);
    for (int c = 0; c < 6; c++) begin
      @(negedge clk);
      pwm_in = (c != 4);
      sync_on = (c == 5);
      wr(REG_FRM_CTL, (c == 5) ? 8'h00 : 8'h01);
      wr(REG_DELAY + 8'h01, 8'(cdly[c]));
      wr(REG_PWM_CTL, cctl[c]);
      ep = (c == 5) ? 50 : 64;
      el = cctl[c][5] ? (k * inten) >> 8 : k;
      if (c == 4) el = 0;
      ed = cdly[c] + (cctl[c][4] ? ep / 16 : 0);
      meas();
      `CHK("on_len", 1'b1, near(len, el))
      if (el > 0) begin
        `CHK("lag", 1'b1, near(d, ed))
        `CHK("period", 1'b1, near(p, ep))
      end
    end
    wr(REG_PWM_CTL, 8'h03);
    repeat (8) begin
      pwm_in = 1'($urandom);
      repeat (6) @(negedge clk);
      `CHK("direct", {16{pwm_in}}, drive)
    end
    // square wave of 64 clk, high 16: string 1 trails by 64/16
    wr(REG_PWM_CTL, 8'h07);
    q0 = -1;
    q1 = -1;
    len = 0;
    for (n = 0; n < 640; n++) begin
      @(negedge clk);
      if (n >= 320 && drive[0] && !dprev[0] && q0 < 0) q0 = n;
      if (q0 >= 0 && drive[1] && !dprev[1] && q1 < 0) q1 = n;
      if (q0 >= 0 && n < q0 + 64 && drive[0]) len++;
      dprev = drive;
      pwm_in = (n % 64) < 16;
    end
    `CHK("dir_len", 1'b1, near(len, 16))
    `CHK("dir_lag", 1'b1, near(q1 - q0, 4))
    wr(REG_PWM_CTL, 8'h01);
    wr(REG_FRM_CTL, 8'h01);
    wr(REG_OPT, 8'h02);
    k = 0;
    repeat (6554) begin
      @(negedge clk);
      k += (opt_req === 1'b1);
    end
    `CHK("opt_pulses", 1'b1, near(k, 4))
    results();
  end
endmodule
